// *** spm_pkg.sv ***
// Shared constants, enumerations and carrier types of the SPI master byte engine.
`default_nettype none
package spm_pkg;

   // System clock and the fastest legal serial clock.
   localparam int CLK_PERIOD_PS = 10000;
   localparam int SCLK_MIN_PERIOD_PS = 39680;
   // Least half period of the serial clock, rounded up to whole system cycles.
   localparam int MIN_HALF_CYCLES =
      (SCLK_MIN_PERIOD_PS + 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS);

   // Field widths of the configuration and of the half-period counter.
   localparam int DIV_W = 8;
   localparam int DELAY_W = 8;
   localparam int COUNT_W = 16;
   localparam int HALF_W = 10;

   // Shift sequencing: sixteen clock edges make one byte.
   localparam logic [3:0] FIRST_EDGE = 4'h0;
   localparam logic [3:0] LAST_EDGE = 4'hF;

   // Values after reset, idle and select levels, and the receive-only fill byte.
   localparam logic [1:0] SS_IDLE = 2'h3;
   localparam logic [1:0] SS_SEL0 = 2'h2;
   localparam logic [1:0] SS_SEL1 = 2'h1;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] RX_ONLY_FILL = 8'hFF;
   localparam logic [HALF_W-1:0] HALF_RESET = 10'h000;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

   typedef enum logic [1:0] {
      DUPLEX_FULL = 2'b00,
      DUPLEX_TX_ONLY = 2'b01,
      DUPLEX_RX_ONLY = 2'b10
   } spm_duplex_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SELECT = 3'b001,
      ST_LOAD = 3'b010,
      ST_SHIFT = 3'b011,
      ST_BYTE_END = 3'b100,
      ST_DESELECT = 3'b101
   } spm_state_e;

   typedef struct packed {
      logic [DIV_W-1:0] clkDiv;
      logic cpol;
      logic cpha;
      logic [DELAY_W-1:0] ssDelay;
      spm_duplex_e duplex;
      logic ssSel;
      logic [COUNT_W-1:0] dataBytes;
   } spm_cfg_s;

   typedef struct packed {
      logic txDone;
      logic rxFullInt;
   } spm_flags_s;

   localparam spm_cfg_s CFG_RESET = '0;
   localparam spm_flags_s FLAGS_RESET = '0;

endpackage

`default_nettype wire

// *** spm_master.sv ***
// SPI master byte engine with its two-entry byte buffers.
`timescale 1ns/1ps
`default_nettype none

module spm_pair_buf #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   logic [WIDTH-1:0] spare;
   logic spareValid;
   logic push;
   logic pop;
   logic next_outValid;
   logic next_spareValid;

   // A push is only possible while the spare slot is free, so a pop and a
   // push together never need both slots to move at once.
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      next_outValid = outValid;
      next_spareValid = spareValid;
      if (pop) begin
         next_outValid = spareValid || push;
         next_spareValid = 1'b0;
      end else if (push) begin
         if (outValid) begin
            next_spareValid = 1'b1;
         end else begin
            next_outValid = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         outValid <= 1'b0;
         spareValid <= 1'b0;
         inReady <= 1'b0;
      end else begin
         outValid <= next_outValid;
         spareValid <= next_spareValid;
         inReady <= !next_spareValid;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         outData <= '0;
         spare <= '0;
      end else begin
         if (pop) begin
            outData <= spareValid ? spare : inData;
         end else if (push && !outValid) begin
            outData <= inData;
         end
         if (push && outValid && !pop) begin
            spare <= inData;
         end
      end
   end
endmodule

module spm_master (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Transfer control
   input wire logic start,
   input wire spm_pkg::spm_cfg_s cfg,
   output logic busy,
   // Bytes to send
   input wire logic txValid,
   output logic txReady,
   input wire logic [7:0] txData,
   // Bytes received
   output logic rxValid,
   input wire logic rxReady,
   output logic [7:0] rxData,
   // Completion flags
   input wire spm_pkg::spm_flags_s flagClear,
   output spm_pkg::spm_flags_s flags,
   // Serial pins
   output logic sclk,
   output logic mosi,
   input wire logic miso,
   output logic [1:0] ssN
);
   logic misoMeta;
   logic misoSync;
   spm_pkg::spm_state_e state;
   spm_pkg::spm_cfg_s act;
   logic [spm_pkg::HALF_W-1:0] halfCnt;
   logic [spm_pkg::HALF_W-1:0] halfLast;
   logic [3:0] edgeCnt;
   logic [7:0] shiftOut;
   logic [7:0] shiftIn;
   logic [7:0] loadByte;
   logic [spm_pkg::COUNT_W-1:0] remaining;
   logic isCmd;
   logic halfEnd;
   logic sampleEdge;
   logic needTx;
   logic keepRx;
   logic loadGo;
   logic byteEnd;
   logic txHeadValid;
   logic [7:0] txHeadData;
   logic rxPushReady;
   logic rxPush;

   // Bytes from the I/O bus wait here until the shifter takes them.
   spm_pair_buf #(
      .WIDTH(8)
   ) txBuf (
      .clock(clock),
      .reset_n(reset_n),
      .inValid(txValid),
      .inReady(txReady),
      .inData(txData),
      .outValid(txHeadValid),
      .outReady(loadGo && needTx),
      .outData(txHeadData)
   );

   // A reader that stalls fills this buffer and then holds the shifter.
   spm_pair_buf #(
      .WIDTH(8)
   ) rxBuf (
      .clock(clock),
      .reset_n(reset_n),
      .inValid(rxPush),
      .inReady(rxPushReady),
      .inData(shiftIn),
      .outValid(rxValid),
      .outReady(rxReady),
      .outData(rxData)
   );

   // Half period is clkDiv plus the least legal half period, in cycles.
   assign halfLast = spm_pkg::HALF_W'(act.clkDiv)
      + spm_pkg::HALF_W'(spm_pkg::MIN_HALF_CYCLES - 1);
   assign halfEnd = halfCnt == halfLast;
   // Even edges lead; phase 0 samples on leading, phase 1 on trailing.
   assign sampleEdge = edgeCnt[0] == act.cpha;
   // The command byte always comes from software; receive-only data bytes
   // send a fixed fill and keep what arrives.
   assign needTx = isCmd || (act.duplex != spm_pkg::DUPLEX_RX_ONLY);
   assign keepRx = (act.duplex == spm_pkg::DUPLEX_FULL)
      || ((act.duplex == spm_pkg::DUPLEX_RX_ONLY) && !isCmd);
   assign loadGo = (state == spm_pkg::ST_LOAD) && (!needTx || txHeadValid);
   assign loadByte = needTx ? txHeadData : spm_pkg::RX_ONLY_FILL;
   assign rxPush = (state == spm_pkg::ST_BYTE_END) && keepRx && rxPushReady;
   assign byteEnd = (state == spm_pkg::ST_BYTE_END) && (!keepRx || rxPushReady);

   // MISO comes from the pin; two flops before anything reads it.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         misoMeta <= 1'b0;
         misoSync <= 1'b0;
      end else begin
         misoMeta <= miso;
         misoSync <= misoMeta;
      end
   end

   // Transfer sequencing.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state <= spm_pkg::ST_IDLE;
         act <= spm_pkg::CFG_RESET;
         busy <= 1'b0;
         isCmd <= 1'b0;
         remaining <= spm_pkg::COUNT_RESET;
         halfCnt <= spm_pkg::HALF_RESET;
         edgeCnt <= spm_pkg::FIRST_EDGE;
      end else begin
         case (state)
            spm_pkg::ST_IDLE: begin
               halfCnt <= spm_pkg::HALF_RESET;
               if (start) begin
                  // Configuration is frozen for the whole transfer.
                  act <= cfg;
                  busy <= 1'b1;
                  isCmd <= 1'b1;
                  remaining <= cfg.dataBytes;
                  state <= spm_pkg::ST_SELECT;
               end
            end
            spm_pkg::ST_SELECT: begin
               if (halfCnt == spm_pkg::HALF_W'(act.ssDelay)) begin
                  halfCnt <= spm_pkg::HALF_RESET;
                  state <= spm_pkg::ST_LOAD;
               end else begin
                  halfCnt <= halfCnt + 1'b1;
               end
            end
            spm_pkg::ST_LOAD: begin
               halfCnt <= spm_pkg::HALF_RESET;
               edgeCnt <= spm_pkg::FIRST_EDGE;
               if (loadGo) begin
                  state <= spm_pkg::ST_SHIFT;
               end
            end
            spm_pkg::ST_SHIFT: begin
               if (halfEnd) begin
                  halfCnt <= spm_pkg::HALF_RESET;
                  edgeCnt <= edgeCnt + 1'b1;
                  if (edgeCnt == spm_pkg::LAST_EDGE) begin
                     state <= spm_pkg::ST_BYTE_END;
                  end
               end else begin
                  halfCnt <= halfCnt + 1'b1;
               end
            end
            spm_pkg::ST_BYTE_END: begin
               if (byteEnd) begin
                  isCmd <= 1'b0;
                  if (remaining == spm_pkg::COUNT_RESET) begin
                     state <= spm_pkg::ST_DESELECT;
                  end else begin
                     remaining <= remaining - 1'b1;
                     state <= spm_pkg::ST_LOAD;
                  end
               end
            end
            spm_pkg::ST_DESELECT: begin
               // Select stays high at least one half period before a restart.
               if (halfEnd) begin
                  halfCnt <= spm_pkg::HALF_RESET;
                  busy <= 1'b0;
                  state <= spm_pkg::ST_IDLE;
               end else begin
                  halfCnt <= halfCnt + 1'b1;
               end
            end
            default: begin
               busy <= 1'b0;
               state <= spm_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Slave selects.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ssN <= spm_pkg::SS_IDLE;
      end else if ((state == spm_pkg::ST_IDLE) && start) begin
         ssN <= cfg.ssSel ? spm_pkg::SS_SEL1 : spm_pkg::SS_SEL0;
      end else if ((state == spm_pkg::ST_DESELECT) || (state == spm_pkg::ST_IDLE)) begin
         ssN <= spm_pkg::SS_IDLE;
      end
   end

   // Serial clock, made here from the system clock.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sclk <= 1'b0;
      end else if (state == spm_pkg::ST_IDLE) begin
         sclk <= cfg.cpol;
      end else if ((state == spm_pkg::ST_SHIFT) && halfEnd) begin
         sclk <= !sclk;
      end
   end

   // Shift registers. MISO is taken from the synchroniser at the sample edge,
   // so it reflects the pin two cycles earlier; a slow slave needs clkDiv
   // raised until its output is settled by then.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         mosi <= 1'b0;
         shiftOut <= spm_pkg::BYTE_RESET;
         shiftIn <= spm_pkg::BYTE_RESET;
      end else if (loadGo) begin
         if (!act.cpha) begin
            mosi <= loadByte[7];
            shiftOut <= {loadByte[6:0], 1'b0};
         end else begin
            shiftOut <= loadByte;
         end
      end else if ((state == spm_pkg::ST_SHIFT) && halfEnd) begin
         if (sampleEdge) begin
            shiftIn <= {shiftIn[6:0], misoSync};
         end else begin
            mosi <= shiftOut[7];
            shiftOut <= {shiftOut[6:0], 1'b0};
         end
      end
   end

   // Per-byte flags; a new byte end wins over a clear in the same cycle.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         flags <= spm_pkg::FLAGS_RESET;
      end else begin
         flags.txDone <= byteEnd || (flags.txDone && !flagClear.txDone);
         flags.rxFullInt <= byteEnd || (flags.rxFullInt && !flagClear.rxFullInt);
      end
   end
endmodule

`default_nettype wire

// *** spm_master_sva.sv ***
// Port checker of the SPI master byte engine.
`timescale 1ns/1ps
`default_nettype none
module spm_master_sva (
   // Watched ports
   input wire logic clock,
   input wire logic reset_n,
   input wire logic start,
   input wire spm_pkg::spm_cfg_s cfg,
   input wire logic busy,
   input wire logic rxValid,
   input wire spm_pkg::spm_flags_s flagClear,
   input wire spm_pkg::spm_flags_s flags,
   input wire logic sclk,
   input wire logic [1:0] ssN
);
   logic sclkQ;
   int sinceSel;
   int edges;
   int half;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Counting from the select edge keeps the delay and edge totals exact.
   always_ff @(posedge clock) begin
      sclkQ <= sclk;
      half <= (sclk != sclkQ) ? 1 : half + 1;
      if (ssN == spm_pkg::SS_IDLE) begin
         sinceSel <= 0;
         edges <= 0;
      end else begin
         sinceSel <= sinceSel + 1;
         edges <= edges + ((sclk != sclkQ) ? 1 : 0);
      end
   end
   sequence s_taken;
      start && !busy;
   endsequence
   sequence s_released;
      $rose(ssN == spm_pkg::SS_IDLE);
   endsequence
   a_sel_exclusive: assert property (ssN != 2'h0)
      else $error("both selects low");
   a_start_selects: assert property (s_taken |=> busy && ssN == (cfg.ssSel ? 2'h1 : 2'h2))
      else $error("start did not select");
   a_idle_level: assert property (!busy |=> sclk == $past(cfg.cpol))
      else $error("idle clock level wrong");
   a_first_edge: assert property ($changed(sclk) && ssN != 2'h3 && edges == 0 |->
      sinceSel == cfg.ssDelay + cfg.clkDiv + 4)
      else $error("select to clock delay wrong");
   a_edge_total: assert property (s_released |-> edges == 16 * (cfg.dataBytes + 1))
      else $error("clock edge total wrong");
   a_half_period: assert property ($changed(sclk) && busy |-> half >= cfg.clkDiv + 2)
      else $error("clock half period short");
   a_byte_flags: assert property ($rose(rxValid) && flagClear == 2'h0 |-> flags == 2'h3)
      else $error("byte flags not set");
   a_flag_clear: assert property (flagClear == 2'h3 && !busy |=> flags == 2'h0)
      else $error("flags not cleared");
   a_busy_drops: assert property (s_released |-> busy ##[1:600] !busy)
      else $error("busy stuck after release");
endmodule
bind spm_master spm_master_sva chk (.clock, .reset_n, .start, .cfg, .busy, .rxValid,
   .flagClear, .flags, .sclk, .ssN);
`default_nettype wire

// *** spm_slave_model.sv ***
// Behavioural SPI slave that answers a ramp of bytes and records what it hears.
`timescale 1ns/1ps
`default_nettype none
module spm_slave_model (
   // Serial pins
   input wire logic sclk,
   input wire logic mosi,
   input wire logic selN,
   output logic miso,
   // Mode and answer
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [7:0] base
);
   logic [7:0] got[$];
   logic [7:0] sh;
   logic [7:0] cur;
   int idx = 0;
   int nb = 0;
   assign cur = base + nb[7:0];
   initial miso = 1'b0;
   always @(negedge selN) begin
      idx = 0;
      nb = 0;
      if (!cpha) miso = base[7];
   end
   always @(sclk) begin
      if (!selN && (sclk ^ cpol ^ cpha)) begin
         sh = {sh[6:0], mosi};
         idx++;
         if (idx == 8) begin
            got.push_back(sh);
            idx = 0;
            nb++;
         end
      end else if (!selN) begin
         miso = cur[3'd7 - idx[2:0]];
      end
   end
   // A released line must not look like a held bit, so it flips.
   always @(posedge selN) miso = ~miso;
endmodule
`default_nettype wire

// *** spm_master_tb.sv ***
// Self-checking bench of the SPI master byte engine.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
   $display("CHECK FAILED at %0t: got %h want %h", $time, a, e); end end
module spm_master_tb;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic start = 1'b0;
   logic txValid = 1'b0;
   logic rxReady = 1'b0;
   logic [7:0] txData = 8'h00;
   spm_pkg::spm_cfg_s cfg = '0;
   spm_pkg::spm_flags_s flagClear = '0;
   spm_pkg::spm_flags_s flags;
   logic busy, txReady, rxValid, sclk, mosi;
   logic [7:0] rxData;
   logic [1:0] ssN;
   wire logic miso;
   int failures = 0;
   int cmp_count = 0;
   logic [7:0] got[$];
   always #5 clock = ~clock;
   spm_master dut (.clock, .reset_n, .start, .cfg, .busy, .txValid, .txReady, .txData,
      .rxValid, .rxReady, .rxData, .flagClear, .flags, .sclk, .mosi, .miso, .ssN);
   spm_slave_model slv (.sclk, .mosi, .selN(&ssN), .miso, .cpol(cfg.cpol),
      .cpha(cfg.cpha), .base(8'hB0));
   task automatic push(input logic [7:0] b);
      txData = b;
      txValid = 1'b1;
      // Ready seen at a falling edge stands until the rising edge that takes the byte.
      while (!txReady) @(negedge clock);
      @(negedge clock);
      txValid = 1'b0;
      // One idle edge keeps a following push from raising valid in the same step.
      @(negedge clock);
   endtask
   task automatic run(input logic [7:0] div, input logic pol, pha, input logic [7:0] dly,
      input spm_pkg::spm_duplex_e dx, input logic sel, input int n, input logic late);
      int i, k, m;
      logic [7:0] e;
      got = {};
      slv.got = {};
      k = (dx == spm_pkg::DUPLEX_RX_ONLY) ? 1 : n + 1;
      m = (dx == spm_pkg::DUPLEX_FULL) ? n + 1 : (dx == spm_pkg::DUPLEX_RX_ONLY) ? n : 0;
      cfg = '{div, pol, pha, dly, dx, sel, n[15:0]};
      push(8'hA0);
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      @(negedge clock);
      `CHK(ssN, sel ? spm_pkg::SS_SEL1 : spm_pkg::SS_SEL0)
      fork
         for (int j = 1; j < k; j++) push(8'hA0 + j[7:0]);
         begin
            // A late reader makes the engine stall on a full receive buffer.
            if (late) repeat (400) @(negedge clock);
            while (got.size() < m) begin
               rxReady = rxValid;
               if (rxValid) got.push_back(rxData);
               @(negedge clock);
            end
            rxReady = 1'b0;
         end
      join
      i = 0;
      while (busy && i < 3000) begin
         @(negedge clock);
         i++;
      end
      `CHK(ssN, spm_pkg::SS_IDLE)
      `CHK(slv.got.size(), n + 1)
      for (i = 0; i <= n; i++) begin
         e = (i == 0 || dx != spm_pkg::DUPLEX_RX_ONLY) ? 8'hA0 + i[7:0] : 8'hFF;
         `CHK(slv.got[i], e)
      end
      `CHK(got.size(), m)
      for (i = 0; i < m; i++) begin
         e = 8'hB0 + i[7:0] + ((dx == spm_pkg::DUPLEX_RX_ONLY) ? 8'h01 : 8'h00);
         `CHK(got[i], e)
      end
      `CHK(flags, 2'h3)
      flagClear = 2'h3;
      @(negedge clock);
      flagClear = 2'h0;
      `CHK(flags, 2'h0)
   endtask
   task automatic t_full;
      run(8'h01, 1'b0, 1'b0, 8'h03, spm_pkg::DUPLEX_FULL, 1'b0, 2, 1'b0);
   endtask
   task automatic t_modes;
      for (int j = 0; j < 4; j++) begin
         run(8'h02, j[1], j[0], 8'h00, spm_pkg::DUPLEX_FULL, 1'b1, 1, 1'b0);
      end
   endtask
   task automatic t_half;
      run(8'h01, 1'b1, 1'b0, 8'h01, spm_pkg::DUPLEX_TX_ONLY, 1'b0, 2, 1'b0);
      run(8'h01, 1'b0, 1'b1, 8'h02, spm_pkg::DUPLEX_RX_ONLY, 1'b1, 2, 1'b0);
      run(8'h03, 1'b0, 1'b1, 8'hFF, spm_pkg::DUPLEX_FULL, 1'b0, 0, 1'b0);
   endtask
   task automatic t_stall;
      run(8'h01, 1'b1, 1'b1, 8'h05, spm_pkg::DUPLEX_FULL, 1'b0, 4, 1'b1);
   endtask
   task automatic end_of_test;
      $display("Comparisons %0d, failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clock);
      reset_n = 1'b1;
      @(negedge clock);
      t_full();
      t_modes();
      t_half();
      t_stall();
      end_of_test();
   end
   // All runs need well under 10000 cycles, so 30000 means a hang.
   initial begin
      #300000;
      failures++;
      end_of_test();
   end
endmodule
`default_nettype wire
